/* spu_peer.sv */
// serial slave device model facing the master pins of the unit
// assumes sclk and selN come from the unit; it is clocked by the serial clock and loads its byte on the falling select
`timescale 1ns/1ps
module spu_peer (
    // serial pins
    input  wire logic       sclk,
    input  wire logic       selN,
    input  wire logic       mosi,
    output logic            miso,
    // setup: mode is {cpha, cpol}
    input  wire logic [1:0] mode,
    input  wire logic [7:0] txByte,
    output logic [7:0]      rxByte
);
    logic       outBit   = 1'b0;
    logic [7:0] shiftOut = 8'h00;

    // a released line must not keep its last level: show the inverse
    assign miso = selN ? ~outBit : outBit;

    initial rxByte = 8'h00;

    always @(negedge selN) begin
        shiftOut = txByte;
        outBit   = mode[1] ? ~outBit : txByte[7];
    end

    always @(sclk) begin
        if (!selN) begin
            if ((sclk != mode[0]) != mode[1]) begin
                rxByte <= {rxByte[6:0], mosi};
            end else begin
                outBit   <= mode[1] ? shiftOut[7] : shiftOut[6];
                shiftOut <= shiftOut << 1;
            end
        end
    end
endmodule

/* spu_pkg.sv */
// package of the serial peripheral unit: register map, field layouts, reset values, states
// assumes a classic wishbone slave with 32-bit data and byte addresses
package spu_pkg;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_DATA = 8'h04;
    localparam logic [7:0] ADR_STAT = 8'h08;
    localparam logic [7:0] ADR_MASK = 8'h0c;
    localparam logic [7:0] ADR_SSEL = 8'h10;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] STAT_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [2:0] SSEL_RST = 3'h0;
    localparam logic [7:0] DATA_RST = 8'h00;

    // ************************************************************
    // timing and framing counts
    // ************************************************************
    // half serial clock period at the fastest rate, in system clocks
    localparam logic [4:0] HALF_BASE     = 5'h02;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // ************************************************************
    // field layouts
    // ************************************************************
    typedef struct packed {
        logic [1:0] spare;
        logic [1:0] rate;
        logic       cpha;
        logic       cpol;
        logic       master;
        logic       enable;
    } spu_ctrl_t;

    typedef struct packed {
        logic [4:0] spare;
        logic       modeFault;
        logic       writeColl;
        logic       xferDone;
    } spu_stat_t;

    // ************************************************************
    // master sequencer states
    // ************************************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_XFER = 2'b01,
        ST_DONE = 2'b10
    } spu_state_t;

endpackage

/* spu_rate_div.sv */
// serial clock rate divider: one tick per half serial clock period
// assumes run is held high for the whole master exchange
`timescale 1ns/1ps
module spu_rate_div (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // control
    input  wire logic       run,
    input  wire logic [1:0] rate,
    // event
    output logic            tick
);

    // ************************************************************
    // half period counter
    // ************************************************************
    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    logic [4:0] term;

    always_comb begin
        // rates are 4, 8, 16 and 32 system clocks per serial bit
        term    = (spu_pkg::HALF_BASE << rate) - 5'h01; // [RULE_05] [RULE_06]
        tick    = run && (cnt_r == term);
        cnt_nxt = cnt_r;
        if (!run || tick) begin
            cnt_nxt = 5'h00;
        end else begin
            cnt_nxt = cnt_r + 5'h01;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 5'h00;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

endmodule

/* spu_unit.sv */
// serial peripheral unit: master or slave byte exchange behind a classic wishbone slave
// assumes all pin inputs are synchronous to sys_clk; the pad logic resolves the enables
`timescale 1ns/1ps

// Overview of operation
// [RULE_01] software picks master mode (own serial clock) or slave mode (external clock)
// [RULE_02] software sets clock idle polarity and sampling phase, two protocols per polarity
// [RULE_03] shifting and sampling on both data lines follow the one serial clock line
// [RULE_04] full duplex: one bit out and one bit in during each clock period
// [RULE_05] serial bit rate never above a quarter of the system clock
// [RULE_06] master mode offers exactly four software selected serial clock rates
// [RULE_07] master drives eight slave select lines, the addressed one low during exchange
// [RULE_08] writing the data register during a transfer sets the write collision flag
// [RULE_09] master seeing another master flags mode fault and turns its drivers off; code floats clock and master data, drives slave data while selected
// [RULE_10] separate enable keeps the clock pin undriven unless acting as master
// [RULE_11] an external master holds slave select low from before first edge to after last bit
// [RULE_12] each finished byte sets a done flag, pollable or routed to the interrupt
module spu_unit (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // interrupt
    output logic             irq,
    // serial clock pin
    input  wire logic        sclkIn,
    output logic             sclkOut,
    output logic             sclkOeN,
    // master side data pins
    input  wire logic        master_data_in,
    output logic             master_data_out,
    output logic             masterDataOeN,
    // slave side data pins
    input  wire logic        slaveDataIn,
    output logic             slaveDataOut,
    output logic             slaveDataOeN,
    // slave selects
    input  wire logic        slaveSelInN,
    output logic [7:0]       slaveSelOutN
);

    // ************************************************************
    // state
    // ************************************************************
    spu_pkg::spu_ctrl_t  ctrl_r;
    spu_pkg::spu_ctrl_t  ctrl_nxt;
    spu_pkg::spu_stat_t  stat_r;
    spu_pkg::spu_stat_t  stat_nxt;
    spu_pkg::spu_stat_t  mask_r;
    spu_pkg::spu_stat_t  mask_nxt;
    spu_pkg::spu_state_t state_r;
    spu_pkg::spu_state_t state_nxt;
    logic [2:0]          ssel_r;
    logic [2:0]          ssel_nxt;
    logic [7:0]          shift_r;
    logic [7:0]          shift_nxt;
    logic [7:0]          rxData_r;
    logic [7:0]          rxData_nxt;
    logic [3:0]          bitCnt_r;
    logic [3:0]          bitCnt_nxt;
    logic                outBit_r;
    logic                outBit_nxt;
    logic                rxBit_r;
    logic                rxBit_nxt;
    logic                sclk_r;
    logic                sclk_nxt;
    logic                sclkPrev_r;
    logic                sclkPrev_nxt;
    logic [7:0]          ssOut_r;
    logic [7:0]          ssOut_nxt;
    logic                ack_r;
    logic                ack_nxt;
    logic [31:0]         rdat_r;
    logic [31:0]         rdat_nxt;

    // ************************************************************
    // decode and edge events
    // ************************************************************
    logic       busAccess;
    logic       busWrite;
    logic       busRead;
    logic       lowLane;
    logic       isMaster;
    logic       isSlave;
    logic       tick;
    logic       leadEdge;
    logic       trailEdge;
    logic       inBit;
    logic       busy;
    logic       dataWrite;
    logic       byteDone;
    logic       modeFault;
    logic       slaveOff;
    logic [7:0] w1c;

    always_comb begin
        busAccess = wb_cyc_i && wb_stb_i && !ack_r;
        busWrite  = wb_cyc_i && wb_stb_i && wb_we_i && ack_r; // writes commit at the edge that completes the handshake
        busRead   = busAccess && !wb_we_i;
        // every register sits in byte lane 0
        lowLane   = wb_sel_i[0];
        isMaster  = ctrl_r.enable && ctrl_r.master; // [RULE_01]
        isSlave   = ctrl_r.enable && !ctrl_r.master; // [RULE_01]
        slaveOff  = slaveSelInN;
        // another master pulling our select low while we lead the bus
        modeFault = isMaster && !slaveSelInN; // [RULE_09]
        leadEdge  = 1'b0;
        trailEdge = 1'b0;
        // leading edge leaves the idle level, trailing edge returns to it
        if (isMaster && (state_r == spu_pkg::ST_XFER)) begin
            leadEdge  = tick && (sclk_r == ctrl_r.cpol); // [RULE_03]
            trailEdge = tick && (sclk_r != ctrl_r.cpol); // [RULE_03]
        end else if (isSlave && !slaveOff) begin
            leadEdge  = (sclkIn != sclkPrev_r) && (sclkPrev_r == ctrl_r.cpol); // [RULE_03]
            trailEdge = (sclkIn != sclkPrev_r) && (sclkPrev_r != ctrl_r.cpol); // [RULE_03]
        end
        inBit     = isMaster ? master_data_in : slaveDataIn;
        busy      = (isMaster && (state_r != spu_pkg::ST_IDLE))
                    || (isSlave && !slaveOff && (bitCnt_r != 4'h0));
        dataWrite = busWrite && lowLane && (wb_adr_i == spu_pkg::ADR_DATA);
        byteDone  = trailEdge && (bitCnt_r == (spu_pkg::BITS_PER_BYTE - 4'h1));
        w1c       = (busWrite && lowLane && (wb_adr_i == spu_pkg::ADR_STAT)) ? wb_dat_i[7:0] : 8'h00;
    end

    spu_rate_div u_rate_div (
        .sys_clk (sys_clk),
        .rst     (rst),
        .run     (isMaster && (state_r == spu_pkg::ST_XFER)),
        .rate    (ctrl_r.rate),
        .tick    (tick)
    );

    // ************************************************************
    // register file and bus answer
    // ************************************************************
    always_comb begin
        ctrl_nxt = ctrl_r;
        mask_nxt = mask_r;
        ssel_nxt = ssel_r;
        ack_nxt  = busAccess;
        rdat_nxt = rdat_r;
        if (busWrite && lowLane) begin
            case (wb_adr_i)
                spu_pkg::ADR_CTRL: begin
                    ctrl_nxt = spu_pkg::spu_ctrl_t'(wb_dat_i[7:0]); // [RULE_01] [RULE_02] [RULE_06]
                    ctrl_nxt.spare = 2'b00;
                end
                spu_pkg::ADR_MASK: begin
                    mask_nxt = spu_pkg::spu_stat_t'(wb_dat_i[7:0]);
                    mask_nxt.spare = 5'h00;
                end
                spu_pkg::ADR_SSEL: begin
                    ssel_nxt = wb_dat_i[2:0];
                end
                default: ssel_nxt = ssel_r;
            endcase
        end
        // a mode fault drops master mode, which releases the clock and master data drivers
        if (modeFault) begin
            ctrl_nxt.master = 1'b0; // [RULE_09]
        end
        if (busRead) begin
            case (wb_adr_i)
                spu_pkg::ADR_CTRL: rdat_nxt = {24'h000000, ctrl_r};
                spu_pkg::ADR_DATA: rdat_nxt = {24'h000000, rxData_r};
                spu_pkg::ADR_STAT: rdat_nxt = {24'h000000, stat_r};
                spu_pkg::ADR_MASK: rdat_nxt = {24'h000000, mask_r};
                spu_pkg::ADR_SSEL: rdat_nxt = {29'h00000000, ssel_r};
                default:           rdat_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= spu_pkg::spu_ctrl_t'(spu_pkg::CTRL_RST);
            mask_r <= spu_pkg::spu_stat_t'(spu_pkg::MASK_RST);
            ssel_r <= spu_pkg::SSEL_RST;
            ack_r  <= 1'b0;
            rdat_r <= 32'h00000000;
        end else begin
            ctrl_r <= ctrl_nxt;
            mask_r <= mask_nxt;
            ssel_r <= ssel_nxt;
            ack_r  <= ack_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    // ************************************************************
    // sticky status and interrupt
    // ************************************************************
    always_comb begin
        // a new event in the clearing cycle survives the clear
        stat_nxt = spu_pkg::spu_stat_t'(stat_r & ~spu_pkg::spu_stat_t'(w1c));
        if (byteDone) begin
            stat_nxt.xferDone = 1'b1; // [RULE_12]
        end
        if (dataWrite && busy) begin
            stat_nxt.writeColl = 1'b1; // [RULE_08]
        end
        if (modeFault) begin
            stat_nxt.modeFault = 1'b1; // [RULE_09]
        end
        stat_nxt.spare = 5'h00;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stat_r <= spu_pkg::spu_stat_t'(spu_pkg::STAT_RST);
        end else begin
            stat_r <= stat_nxt;
        end
    end

    // ************************************************************
    // shifter and sequencer
    // ************************************************************
    always_comb begin
        state_nxt    = state_r;
        shift_nxt    = shift_r;
        rxData_nxt   = rxData_r;
        bitCnt_nxt   = bitCnt_r;
        outBit_nxt   = outBit_r;
        rxBit_nxt    = rxBit_r;
        sclk_nxt     = sclk_r;
        sclkPrev_nxt = sclkIn;
        ssOut_nxt    = 8'hff;
        // a colliding write is dropped so the byte on the wire stays intact
        if (dataWrite && !busy && ctrl_r.enable) begin
            shift_nxt  = wb_dat_i[7:0];
            outBit_nxt = wb_dat_i[7];
            bitCnt_nxt = 4'h0;
        end
        // phase 0 samples on the leading edge and shifts on the trailing one
        if (leadEdge) begin
            if (ctrl_r.cpha) begin
                outBit_nxt = shift_r[7]; // [RULE_02] [RULE_04]
            end else begin
                rxBit_nxt = inBit; // [RULE_02] [RULE_04]
            end
        end
        if (trailEdge) begin
            if (ctrl_r.cpha) begin
                shift_nxt = {shift_r[6:0], inBit}; // [RULE_04]
            end else begin
                shift_nxt  = {shift_r[6:0], rxBit_r}; // [RULE_04]
                outBit_nxt = shift_r[6];
            end
            bitCnt_nxt = bitCnt_r + 4'h1;
        end
        if (byteDone) begin
            rxData_nxt = ctrl_r.cpha ? {shift_r[6:0], inBit} : {shift_r[6:0], rxBit_r};
            bitCnt_nxt = 4'h0;
        end
        // the slave restarts its bit count whenever it is deselected
        if (isSlave && slaveOff) begin
            bitCnt_nxt = 4'h0; // [RULE_11]
        end
        case (state_r)
            spu_pkg::ST_IDLE: begin
                sclk_nxt = ctrl_r.cpol; // [RULE_02]
                if (isMaster && dataWrite) begin
                    state_nxt = spu_pkg::ST_XFER;
                end
            end
            spu_pkg::ST_XFER: begin
                ssOut_nxt[ssel_r] = 1'b0; // [RULE_07]
                sclk_nxt          = tick ? !sclk_r : sclk_r;
                if (byteDone) begin
                    state_nxt = spu_pkg::ST_DONE;
                end
            end
            spu_pkg::ST_DONE: begin
                // select is released one cycle after the last clock edge
                sclk_nxt  = ctrl_r.cpol;
                state_nxt = spu_pkg::ST_IDLE;
            end
            default: state_nxt = spu_pkg::ST_IDLE;
        endcase
        if (!isMaster) begin
            state_nxt = spu_pkg::ST_IDLE; // [RULE_09]
            sclk_nxt  = ctrl_r.cpol;
            ssOut_nxt = 8'hff;
            if (state_r != spu_pkg::ST_IDLE) begin
                bitCnt_nxt = 4'h0;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r    <= spu_pkg::ST_IDLE;
            shift_r    <= spu_pkg::DATA_RST;
            rxData_r   <= spu_pkg::DATA_RST;
            bitCnt_r   <= 4'h0;
            outBit_r   <= 1'b0;
            rxBit_r    <= 1'b0;
            sclk_r     <= 1'b0;
            sclkPrev_r <= 1'b0;
            ssOut_r    <= 8'hff;
        end else begin
            state_r    <= state_nxt;
            shift_r    <= shift_nxt;
            rxData_r   <= rxData_nxt;
            bitCnt_r   <= bitCnt_nxt;
            outBit_r   <= outBit_nxt;
            rxBit_r    <= rxBit_nxt;
            sclk_r     <= sclk_nxt;
            sclkPrev_r <= sclkPrev_nxt;
            ssOut_r    <= ssOut_nxt;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // enables are low while driving; a faulted master floats clock and master data but drives slave data while its select is low
    assign sclkOut         = sclk_r;
    assign sclkOeN         = !isMaster; // [RULE_10]
    assign master_data_out = outBit_r;
    assign masterDataOeN   = !isMaster; // [RULE_09]
    assign slaveDataOut    = outBit_r;
    assign slaveDataOeN    = !(isSlave && !slaveOff);
    assign slaveSelOutN    = ssOut_r;
    assign wb_ack_o        = ack_r;
    assign wb_dat_o        = rdat_r;
    assign irq             = |(stat_r & mask_r);

endmodule

/* spu_unit_bench.sv */
// self-checking bench of the serial peripheral unit: registers, master exchanges, fault, slave exchange
// assumes the peer model sits on the master pins; the bench plays the external master on the slave pins
`timescale 1ns/1ps
module spu_unit_bench;
    logic        sys_clk = 1'b0;
    logic        rst     = 1'b1;
    logic        cyc     = 1'b0;
    logic        stb     = 1'b0;
    logic        we      = 1'b0;
    logic [7:0]  adr     = 8'h00;
    logic [3:0]  sel     = 4'h0;
    logic [31:0] datI    = 32'h0;
    logic        sclkIn  = 1'b0;
    logic        sdi     = 1'b0;
    logic        ssInN   = 1'b1;
    logic [31:0] seed    = 32'h0000a441;
    logic [1:0]  pmode   = 2'h0;
    logic [7:0]  peerTx  = 8'h00;
    logic        sclkPrev = 1'b0;
    logic [31:0] datO;
    logic [7:0]  ssOutN, peerRx;
    logic        ack, irq, sclkOut, sclkOeN, mdo, mdi, mdoOeN, sdo, sdoOeN;
    int          bad_count = 0, checks_done = 0, halfCnt = 0, halfSeen = 0;

    always #10 sys_clk = ~sys_clk;

    spu_unit i_dut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack), .irq(irq),
        .sclkIn(sclkIn), .sclkOut(sclkOut), .sclkOeN(sclkOeN), .master_data_in(mdi),
        .master_data_out(mdo), .masterDataOeN(mdoOeN), .slaveDataIn(sdi), .slaveDataOut(sdo),
        .slaveDataOeN(sdoOeN), .slaveSelInN(ssInN), .slaveSelOutN(ssOutN));

    spu_peer i_peer (.sclk(sclkOut), .selN(&ssOutN), .mosi(mdo), .miso(mdi), .mode(pmode),
        .txByte(peerTx), .rxByte(peerRx));

    // ************************************************************
    // helpers
    // ************************************************************
    // cycles between serial clock changes, last value kept
    always @(posedge sys_clk) begin
        sclkPrev <= sclkOut;
        halfCnt  <= (sclkOut !== sclkPrev) ? 1 : halfCnt + 1;
        if (sclkOut !== sclkPrev) halfSeen <= halfCnt;
    end

    function automatic logic [31:0] nextRand(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wbCycle(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [31:0] q);
        int n;
        n = 0;
        @(posedge sys_clk);
        {cyc, stb, we, adr, datI, sel} <= {2'b11, w, a, d, s};
        do begin
            @(posedge sys_clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = datO;
        {cyc, stb, we} <= 3'b000;
        if (n >= 50) chk(n, 0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wbCycle(1'b1, a, d, 4'hf, q);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wbCycle(1'b0, a, 32'h0, 4'hf, q);
        chk(q, e);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic masterRun(input logic [1:0] rate, input logic [1:0] mode, input logic coll);
        logic [7:0]  tx;
        logic [2:0]  ss, msk;
        logic [31:0] q;
        int          n;
        seed = nextRand(seed);
        {msk, ss, peerTx, tx} = seed[21:0];
        pmode = mode;
        wr(spu_pkg::ADR_MASK, msk);
        wr(spu_pkg::ADR_SSEL, ss);
        wr(spu_pkg::ADR_CTRL, {2'h0, rate, mode, 2'b11});
        wr(spu_pkg::ADR_DATA, tx);
        repeat (2) @(posedge sys_clk);
        chk(ssOutN, 8'(~(8'h01 << ss)));
        if (coll) wr(spu_pkg::ADR_DATA, ~tx);
        n = 0;
        do begin
            wbCycle(1'b0, spu_pkg::ADR_STAT, 32'h0, 4'hf, q);
            n++;
        end while (q[0] !== 1'b1 && n < 300);
        chk(q, {coll, 1'b1});
        repeat (3) @(posedge sys_clk);
        chk(irq, |(msk & {1'b0, coll, 1'b1}));
        chk(ssOutN, 8'hff);
        chk(halfSeen, 32'h2 << rate);
        chk(peerRx, tx);
        rdChk(spu_pkg::ADR_DATA, peerTx);
        wr(spu_pkg::ADR_STAT, 32'h7);
        repeat (2) @(posedge sys_clk);
        chk(irq, 1'b0);
        $display("test master rate %0d mode %0d done", rate, mode);
    endtask

    task automatic slaveRun();
        logic [7:0] tx, mine, got;
        seed = nextRand(seed);
        {mine, tx} = seed[15:0];
        wr(spu_pkg::ADR_CTRL, 32'h1);
        wr(spu_pkg::ADR_DATA, tx);
        ssInN <= 1'b0;
        for (int i = 7; i >= 0; i--) begin
            sdi <= mine[i];
            repeat (4) @(posedge sys_clk);
            got[i] = sdo;
            sclkIn <= 1'b1;
            repeat (4) @(posedge sys_clk);
            sclkIn <= 1'b0;
        end
        repeat (4) @(posedge sys_clk);
        chk({sclkOeN, sdoOeN}, 2'b10);
        ssInN <= 1'b1;
        chk(got, tx);
        rdChk(spu_pkg::ADR_DATA, mine);
        rdChk(spu_pkg::ADR_STAT, 32'h1);
        wr(spu_pkg::ADR_STAT, 32'h7);
        $display("test slave done");
    endtask

    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        chk({ack, irq, sclkOeN, ssOutN}, {3'b001, 8'hff});
        rdChk(spu_pkg::ADR_CTRL, spu_pkg::CTRL_RST);
        rdChk(spu_pkg::ADR_DATA, spu_pkg::DATA_RST);
        rdChk(spu_pkg::ADR_STAT, spu_pkg::STAT_RST);
        rdChk(spu_pkg::ADR_MASK, spu_pkg::MASK_RST);
        rdChk(spu_pkg::ADR_SSEL, spu_pkg::SSEL_RST);
        wr(8'h14, 32'hff);
        rdChk(8'h14, 32'h0);
        wr(spu_pkg::ADR_CTRL, 32'h3);
        rdChk(spu_pkg::ADR_CTRL, 32'h3);
        $display("test registers done");
        for (int m = 0; m < 4; m++) begin
            for (int r = 0; r < 4; r++) masterRun(r[1:0], m[1:0], r == m);
        end
        wr(spu_pkg::ADR_CTRL, 32'h3);
        @(posedge sys_clk);
        chk(sclkOeN, 1'b0);
        ssInN <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk({sclkOeN, mdoOeN}, 2'b11);
        ssInN <= 1'b1;
        rdChk(spu_pkg::ADR_STAT, 32'h4);
        rdChk(spu_pkg::ADR_CTRL, 32'h1);
        wr(spu_pkg::ADR_STAT, 32'h7);
        $display("test mode fault done");
        slaveRun();
        report_and_stop();
    end

    // sized for about six times the expected run
    initial begin
        #300000;
        bad_count++;
        report_and_stop();
    end
endmodule

bind spu_unit spu_unit_sva i_sva (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sclkOut(sclkOut), .sclkOeN(sclkOeN),
    .master_data_out(master_data_out), .masterDataOeN(masterDataOeN), .slaveDataOeN(slaveDataOeN),
    .slaveSelInN(slaveSelInN), .slaveSelOutN(slaveSelOutN));

/* spu_unit_sva.sv */
// checker of the serial peripheral unit: bus answers, serial clock pacing, selects and pin enables
// assumes it is bound to spu_unit and sees only that module's ports
`timescale 1ns/1ps
module spu_unit_sva (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // wishbone
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // serial pins
    input wire logic        sclkOut,
    input wire logic        sclkOeN,
    input wire logic        master_data_out,
    input wire logic        masterDataOeN,
    input wire logic        slaveDataOeN,
    input wire logic        slaveSelInN,
    input wire logic [7:0]  slaveSelOutN
);
    // ************************************************************
    // sequences and properties
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence reqTaken;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    sequence selStart;
        $fell(&slaveSelOutN);
    endsequence

    ack_timing_a: assert property (reqTaken |=> wb_ack_o) else $error("ack missing after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000) else $error("upper read bits set");
    sclk_rate_a: assert property ($changed(sclkOut) |=> $stable(sclkOut)) else $error("serial clock too fast");
    sel_single_a: assert property (!(&slaveSelOutN) |-> $onehot(~slaveSelOutN)) else $error("two selects low");
    sel_hold_a: assert property (selStart |=> $stable(slaveSelOutN)[*3]) else $error("select dropped early");
    fault_float_a: assert property ((!slaveSelInN && !sclkOeN) |-> ##[1:2] (sclkOeN && masterDataOeN))
        else $error("drivers still on after fault");
    clk_enable_a: assert property (!sclkOeN |-> (!masterDataOeN && slaveDataOeN))
        else $error("clock driven outside master mode");
    data_edge_a: assert property ($changed(master_data_out) && !(&slaveSelOutN)
        && !(&$past(slaveSelOutN)) |-> $changed(sclkOut)) else $error("data moved off a clock edge");
endmodule
